// ==== design/smpi_ap_core.sv ====
// Application processor side: INIT halt, Startup entry, interrupt gating, INIT redirect.
// Assumes pins arrive asynchronously; link and core strobes are on sys_clk.
//
// Summary of operation
// - Loader abort sets gate, clears control register.
// - INIT interrupt halts until a Startup arrives.
// - Startup vector forms upper bits of address.
// - Startup resumes fetch in 16-bit real mode.
// - Secure Startup clears gate, sets three flags.
// - Boot driver saves context before secure init.
// - Driver checks idle, broadcasts INIT, awaits ready.
// - Halted processor still answers coherency snoops.
// - Driver waits up to 1000 cycles afterwards.
// - Stay halted until loader sends Startup.
// - Startup code sets gate, restores context.
// - No INIT between secure init and Startup.
// - Device interrupts stay pending until gate set.
// - Late SYSTEM_MANAGEMENT_INTERRUPT, INIT, NMI held until gate.
// - Abort clears loader device protection enable.
// - Redirect bit turns external INIT into exception.
// - Security exception uses vector 30, fault class.
// - Exception pushes error code 1 for INIT.
// - Security exception counts as contributory fault.
// - Clear gate blocks every interrupt kind.
// - Secure init sets all three control flags.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "smpi_map.svh"

module smpi_ap_core (
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	smpi_link_if.ap                        link,
	input  wire logic                      secure_init_exec,
	input  wire logic                      core_idle,
	input  wire logic                      ext_init_pin,
	input  wire logic                      nmi_pin,
	input  wire logic                      smi_pin,
	input  wire logic                      dev_irq_pin,
	input  wire logic                      snoop_req,
	output logic                           snoop_ack,
	output logic                           fetch_valid,
	output logic [19:0]                    fetch_addr,
	output logic                           real_mode,
	output logic                           init_reset,
	output logic                           intr_take,
	output logic [3:0]                     intr_kind,
	output logic                           exc_valid,
	output logic [7:0]                     exc_vector,
	output logic [31:0]                    exc_err_code,
	output logic                           exc_fault,
	output logic                           exc_contributory,
	output logic [2:0]                     vcr_flags,
	output smpi_pkg::smpi_ap_state_type    ap_state
);
	import smpi_pkg::*;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] sync3_q;
	logic [3:0] new_ev;

	assign pin_raw[`SMPI_P_DEV]  = dev_irq_pin;
	assign pin_raw[`SMPI_P_INIT] = ext_init_pin;
	assign pin_raw[`SMPI_P_NMI]  = nmi_pin;
	assign pin_raw[`SMPI_P_SMI]  = smi_pin;

	// Device interrupts are levels; the other three count on their rising edge.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end
			if (gi == `SMPI_P_DEV) begin : g_lvl
				assign new_ev[gi] = sync2_q[gi];
			end else begin : g_edge
				assign new_ev[gi] = sync2_q[gi] & ~sync3_q[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	smpi_ap_state_type state_q;
	smpi_ap_state_type state_d;
	logic        gate_q;
	logic        gate_d;
	logic        hold_q;
	logic        hold_d;
	logic [2:0]  vcr_q;
	logic [2:0]  vcr_d;
	logic [3:0]  pend_q;
	logic [3:0]  pend_d;
	logic        busy_q;
	logic        prot_q;
	logic        idle_q;

	wire ipi_fire   = link.ipi_valid & ~busy_q;
	wire init_ipi   = ipi_fire & (link.ipi_kind == SMPI_IPI_INIT);
	wire sipi_ok    = ipi_fire & (link.ipi_kind == SMPI_IPI_STARTUP)
	                  & (state_q == SMPI_AP_HALT);
	wire sipi_sec   = sipi_ok & link.secure_init_done;
	// Halt and the post-INIT hold both keep everything pending.
	wire deliver_ok = gate_q & ~hold_q & (state_q == SMPI_AP_RUN);
	wire [3:0] take;
	assign take[`SMPI_P_SMI]  = deliver_ok & pend_q[`SMPI_P_SMI];
	assign take[`SMPI_P_NMI]  = deliver_ok & pend_q[`SMPI_P_NMI] & ~pend_q[`SMPI_P_SMI];
	assign take[`SMPI_P_INIT] = deliver_ok & pend_q[`SMPI_P_INIT]
	                            & ~pend_q[`SMPI_P_SMI] & ~pend_q[`SMPI_P_NMI];
	assign take[`SMPI_P_DEV]  = deliver_ok & pend_q[`SMPI_P_DEV] & ~|pend_q[3:1];
	wire redirect   = vcr_q[`SMPI_VCR_RINIT];
	wire sx_take    = take[`SMPI_P_INIT] & redirect;
	wire init_norm  = take[`SMPI_P_INIT] & ~redirect;

	assign link.ipi_ready  = ~busy_q;
	assign link.ap_halted  = (state_q == SMPI_AP_HALT);
	assign link.ap_idle    = idle_q;
	assign link.gate       = gate_q;
	assign link.protect_en = prot_q;
	assign ap_state        = state_q;
	assign vcr_flags       = vcr_q;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SMPI_AP_RUN: begin
				if (init_ipi || init_norm) begin
					state_d = SMPI_AP_HALT;
				end
			end
			SMPI_AP_HALT: begin
				if (sipi_ok) begin
					state_d = SMPI_AP_RUN;
				end
			end
		endcase
	end

	// A software set of the gate wins over a hardware clear in the same cycle.
	assign gate_d = link.gate_set ? 1'b1 :
	                (secure_init_exec | sipi_sec) ? 1'b0 : gate_q;
	// Hold starts when INIT is accepted; a new INIT beats a gate set.
	assign hold_d = init_ipi ? 1'b1 : (link.gate_set ? 1'b0 : hold_q);
	assign vcr_d  = (secure_init_exec | sipi_sec) ? `SMPI_VCR_ALL :
	                (link.vcr_clear ? `SMPI_VCR_RESET : vcr_q);
	assign pend_d = (pend_q & ~take) | new_ev;

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= SMPI_AP_RUN;
			gate_q  <= `SMPI_GATE_RESET;
			hold_q  <= 1'b0;
			vcr_q   <= `SMPI_VCR_RESET;
			pend_q  <= 4'h0;
			busy_q  <= 1'b0;
			idle_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			gate_q  <= gate_d;
			hold_q  <= hold_d;
			vcr_q   <= vcr_d;
			pend_q  <= pend_d;
			busy_q  <= ipi_fire;
			idle_q  <= core_idle | (state_q == SMPI_AP_HALT);
		end
	end

	// Loader protection follows the secure-init instruction until cleared on abort.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prot_q <= 1'b0;
		end else if (secure_init_exec) begin
			prot_q <= 1'b1;
		end else if (link.protect_clear) begin
			prot_q <= 1'b0;
		end
	end

	// Snoops are answered in every state, halted or not.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			snoop_ack <= 1'b0;
		end else begin
			snoop_ack <= snoop_req;
		end
	end

	// ------------------------------------------------------------------------
	// Startup entry
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fetch_valid <= 1'b0;
			fetch_addr  <= 20'h00000;
			real_mode   <= 1'b0;
		end else begin
			fetch_valid <= sipi_ok;
			if (sipi_ok) begin
				fetch_addr <= {link.ipi_vector, `SMPI_PAGE_OFFSET};
				real_mode  <= 1'b1;
			end else if (secure_init_exec) begin
				real_mode  <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Delivery and security exception
	// ------------------------------------------------------------------------
	// Exception fields stand from the pulse until the next exception.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			intr_take        <= 1'b0;
			intr_kind        <= 4'h0;
			init_reset       <= 1'b0;
			exc_valid        <= 1'b0;
			exc_vector       <= 8'h00;
			exc_err_code     <= 32'h0000_0000;
			exc_fault        <= 1'b0;
			exc_contributory <= 1'b0;
		end else begin
			intr_take  <= |take & ~sx_take;
			init_reset <= init_norm;
			exc_valid  <= sx_take;
			if (|take) begin
				intr_kind <= take;
			end
			if (sx_take) begin
				exc_vector       <= `SMPI_SX_VECTOR;
				exc_fault        <= 1'b1;
				exc_err_code     <= `SMPI_SX_ERR_INIT;
				exc_contributory <= 1'b1;
			end
		end
	end

endmodule : smpi_ap_core

`default_nettype wire

// ==== common/smpi_map.svh ====
// Named offsets, field positions, reset values and counts for secure MP start-up.
// Assumes inclusion by bare name from package and design files.
`ifndef SMPI_MAP_SVH
`define SMPI_MAP_SVH

// ----------------------------------------------------------------------------
// Exception dispatch
// ----------------------------------------------------------------------------
`define SMPI_SX_VECTOR      8'h1e
`define SMPI_SX_ERR_INIT    32'h0000_0001
`define SMPI_PAGE_OFFSET    12'h000

// ----------------------------------------------------------------------------
// Virtualization control register fields
// ----------------------------------------------------------------------------
`define SMPI_VCR_DPD        0
`define SMPI_VCR_RINIT      1
`define SMPI_VCR_A20        2
`define SMPI_VCR_ALL        3'h7
`define SMPI_VCR_RESET      3'h0
`define SMPI_GATE_RESET     1'b1

// ----------------------------------------------------------------------------
// Pending interrupt slots
// ----------------------------------------------------------------------------
`define SMPI_P_DEV          0
`define SMPI_P_INIT         1
`define SMPI_P_NMI          2
`define SMPI_P_SMI          3

// ----------------------------------------------------------------------------
// Controller registers and timing
// ----------------------------------------------------------------------------
`define SMPI_REG_CTRL       4'h0
`define SMPI_REG_VECT       4'h4
`define SMPI_REG_STAT       4'h8
`define SMPI_CTRL_LAUNCH    0
`define SMPI_CTRL_START     1
`define SMPI_CTRL_ABORT     2
`define SMPI_CTRL_SAVED     3
`define SMPI_INIT_DLY_CYC   10'd1000
`define SMPI_AXI_OKAY       2'h0
`define SMPI_AXI_DECERR     2'h3

`endif

// ==== common/smpi_pkg.sv ====
// Types shared by both ends of the secure MP start-up link.
// Assumes smpi_map.svh is on the include path.
`include "smpi_map.svh"

package smpi_pkg;

	typedef enum logic [1:0] {
		SMPI_IPI_INIT    = 2'h1,
		SMPI_IPI_STARTUP = 2'h2
	} smpi_ipi_type;

	typedef enum logic [1:0] {
		SMPI_AP_RUN  = 2'h1,
		SMPI_AP_HALT = 2'h2
	} smpi_ap_state_type;

	typedef enum logic [6:0] {
		SMPI_BP_IDLE  = 7'h01,
		SMPI_BP_CHECK = 7'h02,
		SMPI_BP_INIT  = 7'h04,
		SMPI_BP_DELAY = 7'h08,
		SMPI_BP_LOAD  = 7'h10,
		SMPI_BP_SIPI  = 7'h20,
		SMPI_BP_ABORT = 7'h40
	} smpi_bp_state_type;

endpackage : smpi_pkg

// ==== common/smpi_link_if.sv ====
// Link between the boot-side controller and one application processor.
// Assumes both ends run on the same sys_clk; no clocking block.
`timescale 1ns/10ps
`default_nettype none

interface smpi_link_if;
	import smpi_pkg::*;

	logic         ipi_valid;
	smpi_ipi_type ipi_kind;
	logic [7:0]   ipi_vector;
	logic         ipi_ready;
	logic         secure_init_done;
	logic         gate_set;
	logic         vcr_clear;
	logic         protect_clear;
	logic         ap_idle;
	logic         ap_halted;
	logic         gate;
	logic         protect_en;

	modport ap (
		input  ipi_valid, ipi_kind, ipi_vector, secure_init_done,
		input  gate_set, vcr_clear, protect_clear,
		output ipi_ready, ap_idle, ap_halted, gate, protect_en
	);

	modport bp (
		output ipi_valid, ipi_kind, ipi_vector, secure_init_done,
		output gate_set, vcr_clear, protect_clear,
		input  ipi_ready, ap_idle, ap_halted, gate, protect_en
	);

endinterface : smpi_link_if

`default_nettype wire

// ==== design/smpi_bp_ctrl.sv ====
// Boot-side controller: launch handshake, INIT broadcast, Startup and abort clean-up.
// Assumes an AXI4-Lite master on sys_clk and one application processor on the link.
`timescale 1ns/10ps
`default_nettype none
`include "smpi_map.svh"

module smpi_bp_ctrl (
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	smpi_link_if.bp                      link,
	input  wire logic [3:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [3:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output smpi_pkg::smpi_bp_state_type  bp_state
);
	import smpi_pkg::*;

	// ------------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------------
	logic        aw_q;
	logic [3:0]  awaddr_q;
	logic        w_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [7:0]  vect_q;
	logic [9:0]  dly_q;
	smpi_bp_state_type st_q;
	smpi_bp_state_type st_d;

	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire wr_go   = aw_q & w_q & ~s_axi_bvalid;
	wire ctrl_wr = wr_go & (awaddr_q == `SMPI_REG_CTRL) & wstrb_q[0];
	wire vect_wr = wr_go & (awaddr_q == `SMPI_REG_VECT) & wstrb_q[0];
	wire wr_map  = (awaddr_q == `SMPI_REG_CTRL) | (awaddr_q == `SMPI_REG_VECT);
	wire rd_go   = s_axi_arvalid & ~s_axi_rvalid;
	wire [31:0] stat_word = {19'h00000, link.protect_en, link.gate, link.ap_halted,
	                         link.ap_idle, 2'h0, st_q};
	wire [31:0] rd_word = (s_axi_araddr == `SMPI_REG_VECT) ? {24'h000000, vect_q} :
	                      (s_axi_araddr == `SMPI_REG_STAT) ? stat_word : 32'h0000_0000;
	wire rd_map  = (s_axi_araddr == `SMPI_REG_CTRL) | (s_axi_araddr == `SMPI_REG_VECT)
	               | (s_axi_araddr == `SMPI_REG_STAT);
	// Launch is refused unless software also states that the context is saved.
	wire go_launch = ctrl_wr & wdata_q[`SMPI_CTRL_LAUNCH] & wdata_q[`SMPI_CTRL_SAVED];
	wire go_start  = ctrl_wr & wdata_q[`SMPI_CTRL_START];
	wire go_abort  = ctrl_wr & wdata_q[`SMPI_CTRL_ABORT];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aw_q <= 1'b0;
			w_q  <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SMPI_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `SMPI_AXI_OKAY : `SMPI_AXI_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SMPI_AXI_OKAY;
			vect_q       <= 8'h00;
		end else begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_map ? `SMPI_AXI_OKAY : `SMPI_AXI_DECERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (vect_wr) begin
				vect_q <= wdata_q[7:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Launch sequence
	// ------------------------------------------------------------------------
	// INIT is offered only in the INIT state, so none follows secure init.
	wire ipi_done = link.ipi_valid & link.ipi_ready;
	// The wait covers exactly the allowed number of cycles, counted from zero.
	wire dly_end  = (dly_q == `SMPI_INIT_DLY_CYC - 10'd1);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			SMPI_BP_IDLE:  if (go_launch) st_d = SMPI_BP_CHECK;
			SMPI_BP_CHECK: if (link.ap_idle) st_d = SMPI_BP_INIT;
			SMPI_BP_INIT:  if (ipi_done) st_d = SMPI_BP_DELAY;
			SMPI_BP_DELAY: if (dly_end) st_d = SMPI_BP_LOAD;
			SMPI_BP_LOAD: begin
				if (go_abort) begin
					st_d = SMPI_BP_ABORT;
				end else if (go_start) begin
					st_d = SMPI_BP_SIPI;
				end
			end
			SMPI_BP_SIPI:  if (ipi_done) st_d = SMPI_BP_IDLE;
			SMPI_BP_ABORT: st_d = SMPI_BP_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q  <= SMPI_BP_IDLE;
			dly_q <= 10'd0;
			link.secure_init_done <= 1'b0;
		end else begin
			st_q  <= st_d;
			dly_q <= (st_q == SMPI_BP_DELAY) ? dly_q + 10'd1 : 10'd0;
			if (st_q == SMPI_BP_DELAY && dly_end) begin
				link.secure_init_done <= 1'b1;
			end else if (st_d == SMPI_BP_IDLE) begin
				link.secure_init_done <= 1'b0;
			end
		end
	end

	// Gate set after Startup stands for the start-up code; abort cleans up all three.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			link.gate_set      <= 1'b0;
			link.vcr_clear     <= 1'b0;
			link.protect_clear <= 1'b0;
		end else begin
			link.gate_set      <= (st_q == SMPI_BP_ABORT) |
			                      ((st_q == SMPI_BP_SIPI) & ipi_done);
			link.vcr_clear     <= (st_q == SMPI_BP_ABORT);
			link.protect_clear <= (st_q == SMPI_BP_ABORT);
		end
	end

	assign link.ipi_valid  = (st_q == SMPI_BP_INIT) | (st_q == SMPI_BP_SIPI);
	assign link.ipi_kind   = (st_q == SMPI_BP_SIPI) ? SMPI_IPI_STARTUP : SMPI_IPI_INIT;
	assign link.ipi_vector = vect_q;
	assign bp_state        = st_q;

endmodule : smpi_bp_ctrl

`default_nettype wire

// ==== sim/smpi_assertions.sv ====
// Concurrent checks on the link between the boot controller and one application processor.
// Assumes both ends share sys_clk and the synchronous active-high srst.
`timescale 1ns/10ps
`default_nettype none

module smpi_assertions (
	input wire logic                   sys_clk,
	input wire logic                   srst,
	input wire logic                   ipi_valid,
	input wire smpi_pkg::smpi_ipi_type ipi_kind,
	input wire logic [7:0]             ipi_vector,
	input wire logic                   ipi_ready,
	input wire logic                   secure_init_done,
	input wire logic                   gate_set,
	input wire logic                   vcr_clear,
	input wire logic                   protect_clear,
	input wire logic                   ap_idle,
	input wire logic                   ap_halted,
	input wire logic                   gate
);
	import smpi_pkg::*;

	logic        acc_init;
	logic        acc_start;
	logic [10:0] init_wait_q;

	assign acc_init = ipi_valid && ipi_ready && ipi_kind == SMPI_IPI_INIT;
	assign acc_start = ipi_valid && ipi_ready && ipi_kind == SMPI_IPI_STARTUP;

	// The INIT-to-secure-init wait is too long for a delay range, so a counter measures it.
	always_ff @(posedge sys_clk) begin
		if (srst || secure_init_done) begin
			init_wait_q <= 11'd0;
		end else if (acc_init) begin
			init_wait_q <= 11'd1;
		end else if (init_wait_q != 11'd0) begin
			init_wait_q <= init_wait_q + 11'd1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_init_halts: assert property (acc_init |=> ap_halted)
		else $error("init accepted but no halt");
	a_halt_holds: assert property (ap_halted && !acc_start |=> ap_halted)
		else $error("halt left without startup");
	a_start_resumes: assert property (ap_halted && acc_start |=> !ap_halted)
		else $error("startup did not resume");
	a_secure_gate: assert property (ap_halted && acc_start && secure_init_done |=> !gate)
		else $error("secure startup left gate set");
	a_gate_restore: assert property (gate_set |=> gate)
		else $error("gate not set after pulse");
	a_abort_group: assert property (vcr_clear |-> gate_set && protect_clear)
		else $error("abort clean-up pulses split");
	a_offer_holds: assert property (ipi_valid && !ipi_ready |=>
		ipi_valid && $stable(ipi_kind) && $stable(ipi_vector))
		else $error("offer changed before accept");
	a_idle_first: assert property ($rose(ipi_valid) && ipi_kind == SMPI_IPI_INIT |->
		$past(ap_idle))
		else $error("init sent to busy processor");
	a_no_late_init: assert property (secure_init_done && ipi_valid |->
		ipi_kind == SMPI_IPI_STARTUP)
		else $error("init sent after secure init");
	a_delay_bound: assert property (init_wait_q <= 11'd1001)
		else $error("secure init not reached in time");

endmodule : smpi_assertions

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench: both link ends joined, driven over AXI4-Lite and the core pins.
// Assumes the package, link interface, design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, a, b); end end
`define WAITF(s) begin n = 0; do begin @(posedge sys_clk); n++; end \
	while (!(s) && n < 2000); if (!(s)) begin `CHK(1'b0, 1'b1) stop_test; end end

module tb;
	import smpi_pkg::*;

	logic              sys_clk = 1'b0;
	logic              srst, secure_init_exec, core_idle, ext_init_pin, nmi_pin, smi_pin;
	logic              dev_irq_pin, snoop_req, snoop_ack, fetch_valid, real_mode, init_reset;
	logic              intr_take, exc_valid, exc_fault, exc_contributory;
	logic [19:0]       fetch_addr;
	logic [3:0]        intr_kind, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [7:0]        exc_vector;
	logic [31:0]       exc_err_code, s_axi_wdata, s_axi_rdata, d;
	logic [2:0]        vcr_flags;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	smpi_ap_state_type ap_state;
	smpi_bp_state_type bp_state;
	int                mismatches, checks_done, n;

	smpi_link_if lnk ();
	smpi_ap_core smpi_ap_core_i (.sys_clk, .srst, .link(lnk.ap), .secure_init_exec, .core_idle,
		.ext_init_pin, .nmi_pin, .smi_pin, .dev_irq_pin, .snoop_req, .snoop_ack, .fetch_valid,
		.fetch_addr, .real_mode, .init_reset, .intr_take, .intr_kind, .exc_valid, .exc_vector,
		.exc_err_code, .exc_fault, .exc_contributory, .vcr_flags, .ap_state);
	smpi_bp_ctrl smpi_bp_ctrl_i (.sys_clk, .srst, .link(lnk.bp), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bp_state);
	smpi_assertions smpi_assertions_i (.sys_clk, .srst, .ipi_valid(lnk.ipi_valid),
		.ipi_kind(lnk.ipi_kind), .ipi_vector(lnk.ipi_vector), .ipi_ready(lnk.ipi_ready),
		.secure_init_done(lnk.secure_init_done), .gate_set(lnk.gate_set),
		.vcr_clear(lnk.vcr_clear), .protect_clear(lnk.protect_clear), .ap_idle(lnk.ap_idle),
		.ap_halted(lnk.ap_halted), .gate(lnk.gate));

	always #5 sys_clk = ~sys_clk;

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	// -------------------------------------------------------------------------
	// Bus cycles
	// -------------------------------------------------------------------------
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		int k;
		k = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 100);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 100) begin `CHK(1'b0, 1'b1) stop_test; end
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		int k;
		k = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 100);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 100) begin `CHK(1'b0, 1'b1) stop_test; end
	endtask : axi_rd

	task automatic wait_state(input logic [6:0] s);
		for (int j = 0; j < 600 && d[6:0] !== s; j++) axi_rd(4'h8, d, r);
		`CHK(d[6:0], s);
		if (d[6:0] !== s) stop_test;
	endtask : wait_state

	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic t_regs;
		axi_rd(4'h8, d, r);
		`CHK(d, 32'h0000_0a01);
		axi_wr(4'h4, 32'h0000_005c, r);
		`CHK(r, 2'h0);
		axi_rd(4'h4, d, r);
		`CHK(d[7:0], 8'h5c);
		axi_rd(4'hc, d, r);
		`CHK(r, 2'h3);
		axi_wr(4'h0, 32'h0000_0001, r);
		axi_rd(4'h8, d, r);
		`CHK(d[6:0], 7'h01);
		$display("regs done");
	endtask : t_regs

	task automatic t_abort;
		axi_wr(4'h0, 32'h0000_0009, r);
		wait_state(SMPI_BP_LOAD);
		`CHK(ap_state, SMPI_AP_HALT);
		snoop_req <= 1'b1;
		nmi_pin <= 1'b1;
		dev_irq_pin <= 1'b1;
		secure_init_exec <= 1'b1;
		@(posedge sys_clk);
		secure_init_exec <= 1'b0;
		nmi_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK(snoop_ack, 1'b1);
		`CHK(vcr_flags, 3'h7);
		`CHK(intr_take, 1'b0);
		snoop_req <= 1'b0;
		axi_wr(4'h0, 32'h0000_0004, r);
		wait_state(SMPI_BP_IDLE);
		`CHK(bp_state, SMPI_BP_IDLE);
		repeat (3) @(posedge sys_clk);
		axi_rd(4'h8, d, r);
		`CHK(vcr_flags, 3'h0);
		`CHK(d[12:11], 2'b01);
		$display("abort done");
	endtask : t_abort

	task automatic t_start;
		axi_wr(4'h0, 32'h0000_0009, r);
		wait_state(SMPI_BP_LOAD);
		`CHK(ap_state, SMPI_AP_HALT);
		axi_wr(4'h0, 32'h0000_0002, r);
		`WAITF(real_mode)
		`CHK(fetch_addr, 20'h5c000);
		`CHK(fetch_valid, 1'b1);
		`CHK(vcr_flags, 3'h7);
		`WAITF(intr_take)
		`CHK(intr_kind, 4'h4);
		`WAITF(intr_take)
		`CHK(intr_kind, 4'h1);
		dev_irq_pin <= 1'b0;
		`CHK(real_mode, 1'b1);
		$display("start done");
	endtask : t_start

	task automatic t_redirect;
		ext_init_pin <= 1'b1;
		@(posedge sys_clk);
		ext_init_pin <= 1'b0;
		`WAITF(exc_valid)
		`CHK(exc_vector, 8'h1e);
		`CHK(exc_err_code, 32'h0000_0001);
		`CHK(exc_fault, 1'b1);
		`CHK(exc_contributory, 1'b1);
		`CHK(init_reset, 1'b0);
		repeat (2) @(posedge sys_clk);
		`CHK(ap_state, SMPI_AP_RUN);
		$display("redirect done");
	endtask : t_redirect

	task automatic t_plain;
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(vcr_flags, 3'h0);
		ext_init_pin <= 1'b1;
		@(posedge sys_clk);
		ext_init_pin <= 1'b0;
		`WAITF(init_reset)
		`CHK(intr_kind, 4'h2);
		`CHK(exc_valid, 1'b0);
		repeat (2) @(posedge sys_clk);
		`CHK(ap_state, SMPI_AP_HALT);
		$display("plain init done");
	endtask : t_plain

	initial begin
		srst = 1'b1;
		core_idle = 1'b1;
		{secure_init_exec, ext_init_pin, nmi_pin, smi_pin, dev_irq_pin, snoop_req} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, d} = '0;
		s_axi_wstrb = 4'hf;
		mismatches = 0;
		checks_done = 0;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs;
		t_abort;
		t_start;
		t_redirect;
		t_plain;
		stop_test;
	end

endmodule : tb

`default_nettype wire
